/* File: src/sw_regs.svh */
// Register offsets, field positions, reset values and timing counts of the safety watchdog
`ifndef SW_REGS_SVH
`define SW_REGS_SVH

`define SW_OFS_CTRL 12'h000
`define SW_OFS_MODE 12'h004
`define SW_OFS_STAT 12'h008
`define SW_OFS_IRQ_ST 12'h00C
`define SW_OFS_IRQ_MASK 12'h010
`define SW_OFS_COUNT 12'h014

`define SW_KEY_MSB 31
`define SW_KEY_LSB 24
`define SW_KEY_VALUE 8'hC4
`define SW_RESTART_BIT 0

`define SW_WDV_MSB 11
`define SW_WDV_LSB 0
`define SW_FIE_BIT 12
`define SW_RSTEN_BIT 13
`define SW_PROC_BIT 14
`define SW_DIS_BIT 15
`define SW_WDD_MSB 27
`define SW_WDD_LSB 16
`define SW_DBG_BIT 28
`define SW_IDLE_BIT 29

`define SW_STAT_UNF_BIT 0
`define SW_STAT_ERR_BIT 1

`define SW_MODE_RESET 32'h3FFF_AFFF
`define SW_STAT_RESET 32'h0000_0000

`define SW_SYS_CLK_HZ 40_000_000
`define SW_SLOW_CLK_HZ 32_768
`define SW_SLOW_DIV (`SW_SYS_CLK_HZ / `SW_SLOW_CLK_HZ)
`define SW_PRESCALE 128

`endif

/* File: src/sw_pkg.sv */
// Types shared by the safety watchdog modules
package sw_pkg;

    typedef struct packed {
        logic [1:0] reserved;
        logic idle_halt;
        logic debug_halt;
        logic [11:0] window_delta_value;
        logic counter_disable;
        logic processor_only_reset;
        logic fault_reset_enable;
        logic fault_irq_enable;
        logic [11:0] counter_reload_value;
    } sw_mode_t;

    typedef struct packed {
        logic window_error_flag;
        logic underflow_flag;
    } sw_flags_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } sw_bus_req_t;

    typedef struct packed {
        logic ph_wr;
        logic ph_rd;
        logic [11:0] addr;
    } sw_ahb_st_t;

    typedef struct packed {
        sw_mode_t mode;
        logic mode_locked;
        logic [11:0] count;
        sw_flags_t flags;
        logic fault;
        sw_flags_t irq_status;
        sw_flags_t irq_mask;
    } sw_core_st_t;

endpackage : sw_pkg

/* File: src/sw_tick_div.sv */
// Enable-pulse divider with synchronous clear
`timescale 1ns/1ps
module sw_tick_div #(
    parameter int DIVIDE = 128
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic en,
    input wire logic clr,
    output logic tick
);
    localparam int W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
    localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
    } sw_div_st_t;

    sw_div_st_t st_q;
    sw_div_st_t st_d;

    assign tick = en && !clr && (st_q.cnt == LAST);

    always_comb begin
        st_d = st_q;
        if (clr) begin
            st_d.cnt = '0;
        end else if (en) begin
            st_d.cnt = (st_q.cnt == LAST) ? '0 : st_q.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : sw_tick_div

/* File: src/sw_ahb_slave.sv */
// AHB-Lite slave front end: zero wait states, word transfers only
`timescale 1ns/1ps
module sw_ahb_slave
    import sw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output sw_bus_req_t req
);
    sw_ahb_st_t st_q;
    sw_ahb_st_t st_d;
    logic take;

    // Non-word sizes are answered OKAY but have no effect
    assign take = hsel && htrans[1] && hready && (hsize == 3'h2);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        st_d = st_q;
        st_d.ph_wr = take && hwrite;
        st_d.ph_rd = take && !hwrite;
        if (take) begin
            st_d.addr = {haddr[11:2], 2'h0};
        end
        req.wr = st_q.ph_wr;
        req.rd = st_q.ph_rd;
        req.addr = st_q.addr;
        req.wdata = hwdata;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : sw_ahb_slave

/* File: src/sw_watchdog.sv */
// Safety watchdog: windowed 12-bit down counter with write-once mode and fault outputs
`timescale 1ns/1ps
`include "sw_regs.svh"
module sw_watchdog
    import sw_pkg::*;
#(
    parameter int SLOW_DIV = `SW_SLOW_DIV,
    parameter int PRESCALE = `SW_PRESCALE
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cpu_debug,
    input wire logic sys_idle,
    output logic irq,
    output logic fault_req,
    output logic fault_proc_only,
    output logic fault_all
);

    sw_bus_req_t req;
    sw_core_st_t st_q;
    sw_core_st_t st_d;

    logic slow_tick;
    logic count_tick;
    logic running;
    logic ctrl_write;
    logic key_ok;
    logic restart_req;
    logic in_window;
    logic restart_ok;
    logic window_error;
    logic mode_write;
    logic underflow;
    logic status_read;
    logic prescale_clr;
    logic any_fault;
    sw_flags_t events;
    sw_flags_t irq_events;
    sw_flags_t irq_clear;
    logic [31:0] status_word;
    logic [31:0] count_word;

    sw_ahb_slave u_bus (
        .clk_sys(clk_sys),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .req(req)
    );

    // Slow clock stands in as a free-running enable from the system clock
    sw_tick_div #(
        .DIVIDE(SLOW_DIV)
    ) u_slow_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(1'b1),
        .clr(1'b0),
        .tick(slow_tick)
    );

    // Prescaler only advances while the counter may run, so halts freeze it too
    sw_tick_div #(
        .DIVIDE(PRESCALE)
    ) u_prescale (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(slow_tick && running),
        .clr(prescale_clr),
        .tick(count_tick)
    );

    // Counting gate from the disable and halt bits
    always_comb begin
        running = !st_q.mode.counter_disable;
        if (cpu_debug && st_q.mode.debug_halt) begin
            running = 1'b0;
        end
        if (sys_idle && st_q.mode.idle_halt) begin
            running = 1'b0;
        end
    end

    // Control register decode
    assign ctrl_write = req.wr && (req.addr == `SW_OFS_CTRL);
    assign key_ok = (req.wdata[`SW_KEY_MSB:`SW_KEY_LSB] == `SW_KEY_VALUE);
    assign restart_req = ctrl_write && key_ok && req.wdata[`SW_RESTART_BIT];

    // The window check applies even while disabled, so a stray restart is still caught
    assign in_window = (st_q.count <= st_q.mode.window_delta_value);
    assign restart_ok = restart_req && in_window;
    assign window_error = restart_req && !in_window;

    // Mode register accepts its first write only
    assign mode_write = req.wr && (req.addr == `SW_OFS_MODE) && !st_q.mode_locked;

    // Underflow when a count step finds the counter already at zero
    assign underflow = count_tick && (st_q.count == 12'h000);

    assign status_read = req.rd && (req.addr == `SW_OFS_STAT);
    assign prescale_clr = restart_ok || mode_write;

    assign events.underflow_flag = underflow;
    assign events.window_error_flag = window_error;
    assign any_fault = underflow || window_error;

    // Interrupt events only when fault interrupts are enabled
    assign irq_events = st_q.mode.fault_irq_enable ? events : '0;

    // Write-one-to-clear on the interrupt status word, plus clear on status read
    always_comb begin
        irq_clear = '0;
        if (req.wr && (req.addr == `SW_OFS_IRQ_ST)) begin
            irq_clear = sw_flags_t'(req.wdata[1:0]);
        end
        if (status_read) begin
            irq_clear = '1;
        end
    end

    // Next-state logic for everything software can see
    always_comb begin
        st_d = st_q;

        if (mode_write) begin
            st_d.mode = sw_mode_t'(req.wdata);
            st_d.mode.reserved = 2'h0;
            st_d.mode_locked = 1'b1;
        end

        // A mode write restarts with the new reload value
        if (mode_write) begin
            st_d.count = req.wdata[`SW_WDV_MSB:`SW_WDV_LSB];
        end else if (restart_ok) begin
            st_d.count = st_q.mode.counter_reload_value;
        end else if (underflow) begin
            st_d.count = st_q.mode.counter_reload_value;
        end else if (count_tick) begin
            st_d.count = st_q.count - 12'h001;
        end

        // Set wins over the read clear so an event in the read cycle survives
        st_d.flags.underflow_flag =
            (st_q.flags.underflow_flag && !status_read) || underflow;
        st_d.flags.window_error_flag =
            (st_q.flags.window_error_flag && !status_read) || window_error;

        // Fault request follows the reset enable and holds until the status read
        if (any_fault && st_q.mode.fault_reset_enable) begin
            st_d.fault = 1'b1;
        end else if (status_read) begin
            st_d.fault = 1'b0;
        end

        st_d.irq_status = (st_q.irq_status & ~irq_clear) | irq_events;

        if (req.wr && (req.addr == `SW_OFS_IRQ_MASK)) begin
            st_d.irq_mask = sw_flags_t'(req.wdata[1:0]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q.mode <= sw_mode_t'(`SW_MODE_RESET);
            st_q.mode_locked <= 1'b0;
            st_q.count <= 12'(`SW_MODE_RESET & 32'h0000_0FFF);
            st_q.flags <= '0;
            st_q.fault <= 1'b0;
            st_q.irq_status <= '0;
            st_q.irq_mask <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Read-back words
    assign status_word = {30'h0, st_q.flags.window_error_flag, st_q.flags.underflow_flag};
    assign count_word = {15'h0, running, 4'h0, st_q.count};

    // Unmapped and write-only locations read as zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                `SW_OFS_MODE: begin
                    hrdata = st_q.mode;
                end
                `SW_OFS_STAT: begin
                    hrdata = status_word;
                end
                `SW_OFS_IRQ_ST: begin
                    hrdata = {30'h0, st_q.irq_status};
                end
                `SW_OFS_IRQ_MASK: begin
                    hrdata = {30'h0, st_q.irq_mask};
                end
                `SW_OFS_COUNT: begin
                    hrdata = count_word;
                end
                default: begin
                    hrdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(st_q.irq_status & st_q.irq_mask);

    // Reset scope split for the reset controller
    assign fault_req = st_q.fault;
    assign fault_proc_only = st_q.fault && st_q.mode.processor_only_reset;
    assign fault_all = st_q.fault && !st_q.mode.processor_only_reset;

endmodule : sw_watchdog

/* File: sim/sw_watchdog_asserts.sv */
// Port-level checker for the safety watchdog
`timescale 1ns/1ps
module sw_watchdog_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cpu_debug,
    input wire logic sys_idle,
    input wire logic irq,
    input wire logic fault_req,
    input wire logic fault_proc_only,
    input wire logic fault_all
);
    logic rd_q, wr_q, lock_q, rd_st;
    logic [9:0] a_q;
    logic [31:0] mode_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Shadow of the write-once register, kept from bus traffic only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            lock_q <= 1'b0;
            mode_q <= 32'h3FFF_AFFF;
        end else begin
            rd_q <= hsel && htrans[1] && hready && hsize == 3'b010 && !hwrite;
            wr_q <= hsel && htrans[1] && hready && hsize == 3'b010 && hwrite;
            if (wr_q && a_q == 10'h001 && !lock_q) begin
                lock_q <= 1'b1;
                mode_q <= {2'b00, hwdata[29:0]};
            end
        end
        a_q <= haddr[11:2];
    end
    assign rd_st = rd_q && a_q == 10'h002;
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_reset_scope: assert property (fault_req == (fault_proc_only | fault_all) && !(fault_proc_only && fault_all))
        else $error("fault scope outputs inconsistent");
    a_fault_sticky: assert property (fault_req && !rd_st |=> fault_req)
        else $error("fault request dropped without status read");
    a_fault_flags: assert property (rd_st && fault_req |-> hrdata[1:0] != 2'b00)
        else $error("fault request with no status flag");
    a_reset_quiet: assert property ($fell(rst) |-> !irq && !fault_req && hrdata == 32'h0)
        else $error("outputs active after reset");
    a_status_layout: assert property (rd_st |-> hrdata[31:2] == 30'h0)
        else $error("status upper bits not zero");
    a_irq_sticky: assert property (irq && !rd_st && !wr_q |=> irq)
        else $error("interrupt dropped without cause");
    a_mode_once: assert property (rd_q && a_q == 10'h001 |-> hrdata == mode_q)
        else $error("mode readback differs from first write");
endmodule : sw_watchdog_asserts
bind sw_watchdog sw_watchdog_asserts u_sw_watchdog_asserts (.clk_sys(clk_sys), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_debug(cpu_debug), .sys_idle(sys_idle), .irq(irq), .fault_req(fault_req),
    .fault_proc_only(fault_proc_only), .fault_all(fault_all));

/* File: sim/sw_rstc_model.sv */
// Reset controller stand-in that counts fault reset requests by scope
`timescale 1ns/1ps
module sw_rstc_model (
    input wire logic clk_sys,
    input wire logic fault_proc_only,
    input wire logic fault_all,
    output int n_proc,
    output int n_all
);
    logic p_q = 1'b0;
    logic a_q = 1'b0;
    initial begin
        n_proc = 0;
        n_all = 0;
    end
    // A held request is one reset, so only rising requests count
    always @(posedge clk_sys) begin
        if (fault_proc_only && !p_q) n_proc <= n_proc + 1;
        if (fault_all && !a_q) n_all <= n_all + 1;
        p_q <= fault_proc_only;
        a_q <= fault_all;
    end
endmodule : sw_rstc_model

/* File: sim/sw_watchdog_test.sv */
// Self-checking bench for the safety watchdog
`timescale 1ns/1ps
`include "sw_regs.svh"
module sw_watchdog_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic cpu_debug = 1'b0;
    logic sys_idle = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, fault_req, fault_proc_only, fault_all;
    logic rd_ph = 1'b0;
    logic [7:0] key;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0 = 0;
    int n_proc, n_all;
    sw_watchdog #(.SLOW_DIV(4), .PRESCALE(4)) u_sw_watchdog (.clk_sys(clk_sys), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cpu_debug(cpu_debug), .sys_idle(sys_idle), .irq(irq),
        .fault_req(fault_req), .fault_proc_only(fault_proc_only), .fault_all(fault_all));
    sw_rstc_model u_sw_rstc_model (.clk_sys(clk_sys), .fault_proc_only(fault_proc_only),
        .fault_all(fault_all), .n_proc(n_proc), .n_all(n_all));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rd_ph) check(hrdata, exp_q.pop_front());
        rd_ph <= hsel && htrans == 2'b10 && !hwrite && hreadyout;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic wait_ready();
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (hreadyout !== 1'b1 && i < 20);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            final_report();
        end
    endtask : wait_ready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Waits on the free cycle count, so a hang here is impossible
    task automatic gap(input int n);
        while (cyc < t0 + n) @(posedge clk_sys);
    endtask : gap
    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask : do_reset
    initial begin
        void'($urandom(32'h1C32));
        do_reset();
        rd(`SW_OFS_MODE, `SW_MODE_RESET);
        rd(`SW_OFS_IRQ_MASK, 32'h0);
        rd(12'h020, 32'h0);
        bus(1'b1, `SW_OFS_CTRL, 32'hC400_0001);
        rd(`SW_OFS_STAT, `SW_STAT_RESET);
        $display("test reset and open window done");
        // Three slow periods after the restart before the mode register is touched
        repeat (3 * 4) @(posedge clk_sys);
        bus(1'b1, `SW_OFS_MODE, 32'h1008_7010);
        t0 = cyc;
        bus(1'b1, `SW_OFS_MODE, 32'h0000_0FFF);
        rd(`SW_OFS_MODE, 32'h1008_7010);
        bus(1'b1, `SW_OFS_IRQ_MASK, 32'h3);
        key = 8'($urandom_range(255));
        if (key == `SW_KEY_VALUE) key = 8'h3B;
        bus(1'b1, `SW_OFS_CTRL, {key, 24'h000001});
        rd(`SW_OFS_STAT, 32'h0);
        bus(1'b1, `SW_OFS_CTRL, 32'hC400_0001);
        repeat (2) @(posedge clk_sys);
        #1;
        check({30'h0, irq, fault_proc_only}, 32'h3);
        rd(`SW_OFS_STAT, 32'h2);
        #1;
        check({30'h0, irq, fault_req}, 32'h0);
        rd(`SW_OFS_STAT, 32'h0);
        $display("test key and window error done");
        gap(200);
        bus(1'b1, `SW_OFS_CTRL, 32'hC400_0001);
        t0 = cyc;
        sys_idle <= 1'b1;
        gap(100);
        cpu_debug <= 1'b1;
        gap(200);
        cpu_debug <= 1'b0;
        gap(340);
        rd(`SW_OFS_STAT, 32'h0);
        // Underflow needs 17 count steps of running time; the debug halt adds 100 cycles
        gap(520);
        #1;
        check({31'h0, irq}, 32'h1);
        bus(1'b1, `SW_OFS_IRQ_MASK, 32'h0);
        #1;
        check({31'h0, irq}, 32'h0);
        bus(1'b1, `SW_OFS_IRQ_MASK, 32'h3);
        bus(1'b1, `SW_OFS_IRQ_ST, 32'h1);
        #1;
        check({31'h0, irq}, 32'h0);
        rd(`SW_OFS_STAT, 32'h1);
        $display("test restart, halts and underflow done");
        do_reset();
        rd(`SW_OFS_MODE, `SW_MODE_RESET);
        bus(1'b1, `SW_OFS_MODE, 32'h0000_A010);
        bus(1'b1, `SW_OFS_IRQ_MASK, 32'h3);
        bus(1'b1, `SW_OFS_CTRL, 32'hC400_0001);
        repeat (2) @(posedge clk_sys);
        #1;
        check({30'h0, irq, fault_all}, 32'h1);
        rd(`SW_OFS_STAT, 32'h2);
        t0 = cyc;
        gap(300);
        rd(`SW_OFS_STAT, 32'h0);
        check(n_proc, 32'h2);
        check(n_all, 32'h1);
        $display("test second reset and full scope done");
        final_report();
    end
endmodule : sw_watchdog_test
